// *** dma_buffer_pair.sv ***
// A/B buffer sequencer for one DMA direction with per-buffer error flags.
// Assumes done pulses only while a buffer is being serviced.
`timescale 1ns/1ns
`default_nettype none
module dma_buffer_pair
	import serial_i2c_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic [1:0] load,
	input  wire logic     dma_rst,
	input  wire logic     done,
	input  wire rx_err_t  err,
	output var  dma_req_t req,
	output logic [1:0]    pend,
	output logic [1:0]    active,
	output logic [5:0]    err_flags
);
	logic [1:0] pend_q, pend_d;
	logic [1:0] frm_q, frm_d, par_q, par_d, ovf_q, ovf_d;
	logic       busy_q, busy_d, sel_q, sel_d, next_q, next_d, start_q, start_d;

	always_comb begin
		pend_d  = pend_q;
		busy_d  = busy_q;
		sel_d   = sel_q;
		next_d  = next_q;
		start_d = 1'b0;
		if (busy_q && done) begin
			pend_d[sel_q] = 1'b0; // RQ11
			busy_d        = 1'b0;
		end else if (!busy_q && pend_q != 2'h0) begin
			// Both loaded: take turns, so neither buffer starves
			sel_d   = (pend_q == 2'h3) ? next_q : pend_q[1]; // RQ17
			next_d  = ~sel_d;
			busy_d  = 1'b1;
			start_d = 1'b1;
		end
		pend_d = pend_d | load; // RQ9 RQ10 RQ12
		for (int b = 0; b < 2; b++) begin
			frm_d[b] = (frm_q[b] & ~(load[b] | dma_rst)) | (busy_q && sel_q == b[0] && err.frame); // RQ16
			par_d[b] = (par_q[b] & ~(load[b] | dma_rst)) | (busy_q && sel_q == b[0] && err.parity);
			ovf_d[b] = (ovf_q[b] & ~(load[b] | dma_rst)) | (busy_q && sel_q == b[0] && err.overrun);
		end
		if (dma_rst) begin
			pend_d  = 2'h0; // RQ7 RQ8
			busy_d  = 1'b0;
			next_d  = 1'b0;
			start_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q  <= 2'h0;
			busy_q  <= 1'b0;
			sel_q   <= 1'b0;
			next_q  <= 1'b0;
			start_q <= 1'b0;
			frm_q   <= 2'h0;
			par_q   <= 2'h0;
			ovf_q   <= 2'h0;
		end else begin
			pend_q  <= pend_d;
			busy_q  <= busy_d;
			sel_q   <= sel_d;
			next_q  <= next_d;
			start_q <= start_d;
			frm_q   <= frm_d;
			par_q   <= par_d;
			ovf_q   <= ovf_d;
		end
	end

	assign req       = '{start: start_q, sel: sel_q};
	assign pend      = pend_q; // RQ13
	assign active    = busy_q ? (sel_q ? 2'h2 : 2'h1) : 2'h0;
	assign err_flags = {frm_q, par_q, ovf_q};

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_done_clears_pend: assert property ((busy_q && done && !dma_rst && !load[sel_q])
		|=> !pend_q[$past(sel_q)]) else $error("finished buffer still pending"); // RQ11
	a_zero_write_kept: assert property ((pend_q[0] && !dma_rst && !(busy_q && done && !sel_q))
		|=> pend_q[0]) else $error("pending buffer A dropped"); // RQ12
	a_alternate_order: assert property ((!busy_q && pend_q == 2'h3 && !dma_rst)
		|=> (start_q && sel_q == $past(next_q))) else $error("buffers not alternated"); // RQ17
	a_active_pending: assert property (busy_q |-> pend_q[sel_q])
		else $error("active buffer reads idle"); // RQ13
endmodule : dma_buffer_pair
`default_nettype wire

// *** i2c_slave_model.sv ***
// Behavioural I2C slave on the resolved two-wire bus.
// Assumes pull-ups: a released line reads one; master outputs are pull-low enables.
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model (
	input  wire logic       clk,
	input  wire logic       scl_oe,
	input  wire logic       sda_oe,
	input  wire logic       rd_mode,
	input  wire logic       nack,
	input  wire logic       stretch,
	input  wire logic [7:0] rd_byte,
	output logic            scl,
	output logic            sda,
	output logic [7:0]      got,
	output logic            ack_seen
);
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic       act = 1'b0;
	logic [3:0] cnt = 4'hf;
	logic [4:0] hold = 5'h0;
	logic       pull;
	// Read mode drives data bits, write mode the ack slot
	assign pull = act && (rd_mode ? (cnt < 4'h8 && !rd_byte[~cnt[2:0]]) : (cnt == 4'h8 && !nack));
	assign scl = ~scl_oe & (hold == 5'h0);
	assign sda = ~sda_oe & ~pull;
	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && scl_q && sda_q && !sda) begin
			cnt <= 4'hf;
			act <= 1'b1;
		end else if (scl && scl_q && !sda_q && sda) begin
			act <= 1'b0;
		end else if (scl_q && !scl && act) begin
			cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
		end else if (!scl_q && scl && act) begin
			if (cnt < 4'h8)
				got <= {got[6:0], sda};
			else if (rd_mode) begin
				ack_seen <= sda;
				// A master NACK ends the read, so SDA is let go for the stop
				act <= !sda;
			end
		end
	end
	// Slow answer: stretch SCL low after each falling edge
	always @(posedge clk)
		if (scl_q && !scl && stretch)
			hold <= 5'h14;
		else if (hold != 5'h0)
			hold <= hold - 5'h1;
endmodule : i2c_slave_model
`default_nettype wire

// *** pin_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the pins idle at RESET_VAL.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int         WIDTH     = 2,
	parameter [WIDTH-1:0] RESET_VAL = '1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q <= RESET_VAL[i];
					sync_q <= RESET_VAL[i];
				end else begin
					meta_q <= d[i];
					sync_q <= meta_q;
				end
			end
			assign q[i] = sync_q;
		end
	endgenerate
endmodule : pin_sync
`default_nettype wire

// *** serial_i2c_defines.svh ***
// Register indices, field positions and timing for the serial I2C/DMA block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef SERIAL_I2C_DEFINES_SVH
`define SERIAL_I2C_DEFINES_SVH

`define REG_DMA_STATUS 16'h4496
`define REG_DMA_CTRL   16'h4498
`define REG_I2C_STATUS 16'h44a2
`define REG_I2C_CMD    16'h44a6
`define REG_I2C_ACK    16'h44a8
`define REG_I2C_DATA   16'h44c0
`define REG_INT_STATUS 16'h44c2
`define REG_INT_MASK   16'h44c4

`define CTRL_RX_LOAD_A 0
`define CTRL_RX_LOAD_B 1
`define CTRL_TX_LOAD_A 2
`define CTRL_TX_LOAD_B 3
`define CTRL_RX_RST    4
`define CTRL_TX_RST    5

`define CMD_RECV  0
`define CMD_SEND  1
`define CMD_START 2
`define CMD_STOP  3

`define STAT_NACK    0
`define STAT_TX_DONE 1
`define STAT_RX_DONE 2
`define STAT_CMD_FIN 3

`define ACK_SELECT 0

`define RESET_WORD 32'h0000_0000
`define ACK_SLOT   4'h8

`define CLK_PERIOD_NS  20
`define I2C_QUARTER_NS 2500

`endif

// *** serial_i2c_pkg.sv ***
// Types shared by the serial I2C/DMA block and its DMA sequencers.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package serial_i2c_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_START = 2'h1,
		ST_BYTE  = 2'h3,
		ST_STOP  = 2'h2
	} i2c_state_t;

	typedef struct packed {
		logic start;
		logic sel;
	} dma_req_t;

	typedef struct packed {
		logic frame;
		logic parity;
		logic overrun;
	} rx_err_t;

endpackage : serial_i2c_pkg
`default_nettype wire

// *** serial_i2c_status_dma_control.sv ***
// I2C master command/status and A/B DMA control registers on Avalon-MM.
// Assumes open-drain pins resolved outside and a DMA engine that pulses done.
// Operation
// [RQ1] Receive command clocks one byte in and clears itself when finished.
// [RQ2] After a received byte, drive ACK if ack-select is one, else NACK.
// [RQ3] Byte-received flag rises once a byte is fully received.
// [RQ4] Byte-sent flag rises once a byte is completely transmitted.
// [RQ5] Not-acknowledged flag rises when the slave NACKs a sent byte.
// [RQ6] Command-finished flag on start/stop end; all four flags clear on next activity.
// [RQ7] Writing one resets transmit DMA; the bit clears itself.
// [RQ8] Writing one resets receive DMA; the bit clears itself.
// [RQ9] Transmit load bit A or B latches addresses and starts that buffer.
// [RQ10] Receive load bit A or B latches addresses and starts that buffer.
// [RQ11] Hardware clears each load bit when its buffer finishes.
// [RQ12] Writing zero to a load bit has no effect.
// [RQ13] A load bit reads one while active or pending, zero otherwise.
// [RQ14] Start command issues a start or repeated start, then clears itself.
// [RQ15] Send command shifts one byte out, then clears itself.
// [RQ16] Receive error flags per buffer clear on that buffer's load or DMA reset.
// [RQ17] Two loaded buffers are serviced one at a time, alternating A and B.
// [RQ18] DMA reset bits always read back as zero.
`include "serial_i2c_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module serial_i2c_status_dma_control
	import serial_i2c_pkg::*;
#(
	parameter int QUARTER_CYCLES = (`I2C_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output var  dma_req_t    tx_dma_req,
	input  wire logic        tx_dma_done,
	output logic             tx_dma_reset_strobe,
	output var  dma_req_t    rx_dma_req,
	input  wire logic        rx_dma_done,
	output logic             rx_dma_reset_strobe,
	input  wire rx_err_t     rx_err
);
	localparam int CW = $clog2(QUARTER_CYCLES) + 1;

	// Bus side
	logic        ack_q, ack_d, req, wr_en;
	logic        wr_ctrl, wr_cmd, wr_ack, wr_data, wr_ist, wr_imask;
	logic [31:0] rdata_q, rdata_d, rmux;
	logic [3:0]  cmd_q, cmd_d, evt_q, evt_d;
	logic        ack_sel_q, ack_sel_d;
	logic [7:0]  tx_data_q, tx_data_d;
	logic [5:0]  int_st_q, int_st_d, int_mask_q, int_mask_d;
	logic        tx_rst_q, tx_rst_d, rx_rst_q, rx_rst_d;
	logic [1:0]  tx_load, rx_load, tx_pend, rx_pend, tx_act, rx_act;
	logic [5:0]  rx_errf;

	// Engine side
	i2c_state_t  state_q, state_d;
	logic [1:0]  phase_q, phase_d;
	logic [3:0]  bit_q, bit_d, cur_q, cur_d, cmd_done_mask, evt_set;
	logic [7:0]  shift_q, shift_d, rx_data_q, rx_data_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic        samp_q, samp_d, hold_q, hold_d;
	logic        scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
	logic        tick, advance, dispatch, bitval, scl_s, sda_s;

	pin_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'h3)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({scl_i, sda_i}),
		.q   ({scl_s, sda_s})
	);

	// One wait state: decode in the first cycle, answer in the second
	assign req         = read | write;
	assign waitrequest = req & ~ack_q;
	assign wr_en       = write & ack_q;
	assign wr_ctrl     = wr_en && address == `REG_DMA_CTRL;
	assign wr_cmd      = wr_en && address == `REG_I2C_CMD;
	assign wr_ack      = wr_en && address == `REG_I2C_ACK;
	assign wr_data     = wr_en && address == `REG_I2C_DATA;
	assign wr_ist      = wr_en && address == `REG_INT_STATUS;
	assign wr_imask    = wr_en && address == `REG_INT_MASK;
	assign tx_load     = wr_ctrl ? {writedata[`CTRL_TX_LOAD_B], writedata[`CTRL_TX_LOAD_A]} : 2'h0;
	assign rx_load     = wr_ctrl ? {writedata[`CTRL_RX_LOAD_B], writedata[`CTRL_RX_LOAD_A]} : 2'h0;
	assign tick        = cnt_q == CW'(QUARTER_CYCLES - 1);

	always_comb begin
		state_d       = state_q;
		phase_d       = phase_q;
		bit_d         = bit_q;
		shift_d       = shift_q;
		samp_d        = samp_q;
		cur_d         = cur_q;
		hold_d        = hold_q;
		rx_data_d     = rx_data_q;
		cnt_d         = tick ? '0 : cnt_q + 1'b1;
		evt_set       = 4'h0;
		cmd_done_mask = 4'h0;
		dispatch      = 1'b0;
		// Slave stretching: wait in the high phase until SCL is seen high
		advance       = tick && !(phase_q == 2'h1 && !scl_s);
		case (state_q)
			ST_IDLE: begin
				if (cmd_q != 4'h0) begin
					dispatch = 1'b1;
					phase_d  = 2'h0;
					bit_d    = 4'h0;
					cnt_d    = '0;
					shift_d  = tx_data_q;
					cur_d    = 4'h0;
					if (cmd_q[`CMD_START]) begin
						cur_d[`CMD_START] = 1'b1; // RQ14
						state_d           = ST_START;
					end else if (cmd_q[`CMD_STOP]) begin
						cur_d[`CMD_STOP] = 1'b1;
						state_d          = ST_STOP;
					end else if (cmd_q[`CMD_SEND]) begin
						cur_d[`CMD_SEND] = 1'b1; // RQ15
						state_d          = ST_BYTE;
					end else begin
						cur_d[`CMD_RECV] = 1'b1; // RQ1
						state_d          = ST_BYTE;
					end
				end
			end
			ST_START, ST_STOP: begin
				if (advance) begin
					phase_d = phase_q + 2'h1;
					if (phase_q == 2'h3) begin
						state_d                = ST_IDLE;
						hold_d                 = state_q == ST_START;
						evt_set[`STAT_CMD_FIN] = 1'b1; // RQ6
						cmd_done_mask          = cur_q;
					end
				end
			end
			ST_BYTE: begin
				if (advance) begin
					phase_d = phase_q + 2'h1;
					if (phase_q == 2'h2) begin
						samp_d = sda_s;
					end
					if (phase_q == 2'h3) begin
						bit_d = bit_q + 4'h1;
						if (bit_q != `ACK_SLOT) begin
							shift_d = {shift_q[6:0], samp_q};
						end else begin
							state_d       = ST_IDLE;
							cmd_done_mask = cur_q;
							if (cur_q[`CMD_RECV]) begin
								evt_set[`STAT_RX_DONE] = 1'b1; // RQ3
								rx_data_d              = shift_q;
							end else begin
								evt_set[`STAT_TX_DONE] = 1'b1; // RQ4
								evt_set[`STAT_NACK]    = samp_q; // RQ5
							end
						end
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// Level the master puts on SDA in the current bit slot
		if (cur_q[`CMD_RECV]) begin
			bitval = (bit_q == `ACK_SLOT) ? ~ack_sel_q : 1'b1; // RQ2
		end else begin
			bitval = (bit_q == `ACK_SLOT) ? 1'b1 : shift_q[7];
		end
		case (state_q)
			ST_START: begin
				scl_oe_d = (phase_q == 2'h0) ? hold_q : (phase_q == 2'h3);
				sda_oe_d = phase_q[1];
			end
			ST_STOP: begin
				scl_oe_d = phase_q == 2'h0;
				sda_oe_d = ~phase_q[1];
			end
			ST_BYTE: begin
				scl_oe_d = phase_q == 2'h0 || phase_q == 2'h3;
				sda_oe_d = ~bitval;
			end
			default: begin
				scl_oe_d = hold_q;
				sda_oe_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= ST_IDLE;
			phase_q   <= 2'h0;
			bit_q     <= 4'h0;
			shift_q   <= 8'h00;
			samp_q    <= 1'b0;
			cur_q     <= 4'h0;
			hold_q    <= 1'b0;
			rx_data_q <= 8'h00;
			cnt_q     <= '0;
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
		end else begin
			state_q   <= state_d;
			phase_q   <= phase_d;
			bit_q     <= bit_d;
			shift_q   <= shift_d;
			samp_q    <= samp_d;
			cur_q     <= cur_d;
			hold_q    <= hold_d;
			rx_data_q <= rx_data_d;
			cnt_q     <= cnt_d;
			scl_oe_q  <= scl_oe_d;
			sda_oe_q  <= sda_oe_d;
		end
	end

	always_comb begin
		case (address)
			`REG_DMA_CTRL:   rmux = {26'h0, 2'h0, tx_pend, rx_pend}; // RQ13 RQ18
			`REG_DMA_STATUS: rmux = {22'h0, rx_errf, tx_act, rx_act};
			`REG_I2C_STATUS: rmux = {28'h0, evt_q};
			`REG_I2C_CMD:    rmux = {28'h0, cmd_q};
			`REG_I2C_ACK:    rmux = {31'h0, ack_sel_q};
			`REG_I2C_DATA:   rmux = {24'h0, rx_data_q};
			`REG_INT_STATUS: rmux = {26'h0, int_st_q};
			`REG_INT_MASK:   rmux = {26'h0, int_mask_q};
			default:         rmux = `RESET_WORD;
		endcase
		ack_d      = req & ~ack_q;
		rdata_d    = (req && !ack_q) ? rmux : rdata_q;
		// Completion clears first so a fresh software write still lands
		cmd_d      = (cmd_q & ~cmd_done_mask) | (wr_cmd ? writedata[3:0] : 4'h0); // RQ1 RQ14 RQ15
		evt_d      = (dispatch ? 4'h0 : evt_q) | evt_set; // RQ6
		ack_sel_d  = wr_ack ? writedata[`ACK_SELECT] : ack_sel_q;
		tx_data_d  = wr_data ? writedata[7:0] : tx_data_q;
		int_mask_d = wr_imask ? writedata[5:0] : int_mask_q;
		int_st_d   = (int_st_q & ~(wr_ist ? writedata[5:0] : 6'h0))
			| {rx_dma_done, tx_dma_done, evt_set};
		tx_rst_d   = wr_ctrl & writedata[`CTRL_TX_RST]; // RQ7
		rx_rst_d   = wr_ctrl & writedata[`CTRL_RX_RST]; // RQ8
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q      <= 1'b0;
			rdata_q    <= `RESET_WORD;
			cmd_q      <= 4'h0;
			evt_q      <= 4'h0;
			ack_sel_q  <= 1'b0;
			tx_data_q  <= 8'h00;
			int_mask_q <= 6'h00;
			int_st_q   <= 6'h00;
			tx_rst_q   <= 1'b0;
			rx_rst_q   <= 1'b0;
		end else begin
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
			cmd_q      <= cmd_d;
			evt_q      <= evt_d;
			ack_sel_q  <= ack_sel_d;
			tx_data_q  <= tx_data_d;
			int_mask_q <= int_mask_d;
			int_st_q   <= int_st_d;
			tx_rst_q   <= tx_rst_d;
			rx_rst_q   <= rx_rst_d;
		end
	end

	dma_buffer_pair u_tx_dma (
		.clk       (clk),
		.rst       (rst),
		.load      (tx_load), // RQ9
		.dma_rst   (tx_rst_q),
		.done      (tx_dma_done),
		.err       (3'h0),
		.req       (tx_dma_req),
		.pend      (tx_pend),
		.active    (tx_act),
		.err_flags ()
	);
	dma_buffer_pair u_rx_dma (
		.clk       (clk),
		.rst       (rst),
		.load      (rx_load), // RQ10
		.dma_rst   (rx_rst_q),
		.done      (rx_dma_done),
		.err       (rx_err),
		.req       (rx_dma_req),
		.pend      (rx_pend),
		.active    (rx_act),
		.err_flags (rx_errf)
	);
	assign readdata            = rdata_q;
	assign irq                 = |(int_st_q & int_mask_q);
	assign scl_o               = 1'b0;
	assign sda_o               = 1'b0;
	assign scl_oe              = scl_oe_q;
	assign sda_oe              = sda_oe_q;
	assign tx_dma_reset_strobe = tx_rst_q;
	assign rx_dma_reset_strobe = rx_rst_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_one_pulse(sig);
		sig ##1 !sig;
	endsequence
	sequence s_start_begin;
		state_q == ST_IDLE && cmd_q[`CMD_START];
	endsequence
	a_recv_autoclear: assert property ((cmd_done_mask[`CMD_RECV] && !(wr_cmd && writedata[`CMD_RECV]))
		|=> !cmd_q[`CMD_RECV]) else $error("receive command not cleared"); // RQ1
	a_ack_slot: assert property ((state_q == ST_BYTE && cur_q[`CMD_RECV] && bit_q == `ACK_SLOT
		&& phase_q == 2'h2 && $stable(ack_sel_q)) |-> sda_oe_q == ack_sel_q)
		else $error("wrong acknowledge level"); // RQ2
	a_rx_flag: assert property (evt_set[`STAT_RX_DONE] |=> evt_q[`STAT_RX_DONE] && rx_data_q == $past(shift_q))
		else $error("received flag or data missing"); // RQ3
	a_tx_flag: assert property (evt_set[`STAT_TX_DONE] |=> evt_q[`STAT_TX_DONE])
		else $error("sent flag missing"); // RQ4
	a_nack_flag: assert property ((evt_set[`STAT_TX_DONE] && samp_q) |=> evt_q[`STAT_NACK])
		else $error("nack flag missing"); // RQ5
	a_flags_clear: assert property (dispatch |=> evt_q == 4'h0 ##1 state_q != ST_IDLE)
		else $error("flags kept on new activity"); // RQ6
	a_tx_reset_strobe: assert property ((wr_ctrl && writedata[`CTRL_TX_RST]) |=> s_one_pulse(tx_rst_q))
		else $error("tx dma reset not a single pulse"); // RQ7
	a_rx_reset_strobe: assert property ((wr_ctrl && writedata[`CTRL_RX_RST]) |=> s_one_pulse(rx_rst_q))
		else $error("rx dma reset not a single pulse"); // RQ8
	a_start_issue: assert property (s_start_begin |=> state_q == ST_START && cur_q[`CMD_START])
		else $error("start condition not issued"); // RQ14
	// Stretching makes the start length open, so check the level per phase
	a_start_low: assert property ((state_q == ST_START && phase_q == 2'h3) |-> sda_oe_q) // RQ14
		else $error("start left data line released");
	a_reset_bits_zero: assert property ((ack_q && read && address == `REG_DMA_CTRL) |-> readdata[5:4] == 2'h0)
		else $error("dma reset bits read nonzero"); // RQ18
endmodule : serial_i2c_status_dma_control
`default_nettype wire

// *** serial_i2c_status_dma_control_tb.sv ***
// Self-checking bench: Avalon-MM register traffic, I2C slave model, DMA done pulses.
// Assumes the design's word-index register map and a short I2C quarter period.
`timescale 1ns/1ns
`default_nettype none
`include "serial_i2c_defines.svh"
module serial_i2c_status_dma_control_tb
	import serial_i2c_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic        tx_dma_done = 1'b0;
	logic        rx_dma_done = 1'b0;
	logic [15:0] address = 16'h0;
	logic [31:0] writedata = 32'h0;
	rx_err_t     rx_err = '0;
	logic [31:0] readdata;
	logic        waitrequest, irq, scl_oe, sda_oe, scl, sda, tx_rs, rx_rs, ack_seen;
	dma_req_t    tx_req, rx_req;
	logic        rd_mode = 1'b0;
	logic        nack = 1'b0;
	logic        stretch = 1'b0;
	logic [7:0]  rd_byte = 8'h0;
	logic [7:0]  got;
	logic        scl_lo, sda_lo;
	int          failures = 0;
	int          n_compared = 0;
	int          starts[2] = '{0, 0};
	int          rsts[2] = '{0, 0};
	logic        sel[2];
	int          b;

	always #10 clk = ~clk;

	serial_i2c_status_dma_control #(.QUARTER_CYCLES(4)) uut (
		.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .irq,
		.scl_i(scl), .scl_o(scl_lo), .scl_oe, .sda_i(sda), .sda_o(sda_lo), .sda_oe,
		.tx_dma_req(tx_req), .tx_dma_done, .tx_dma_reset_strobe(tx_rs),
		.rx_dma_req(rx_req), .rx_dma_done, .rx_dma_reset_strobe(rx_rs), .rx_err
	);

	i2c_slave_model slave (
		.clk, .scl_oe, .sda_oe, .rd_mode, .nack, .stretch, .rd_byte, .scl, .sda, .got, .ack_seen
	);

	always @(posedge clk) begin
		if (rx_req.start === 1'b1) begin
			starts[0]++;
			sel[0] = rx_req.sel;
		end
		if (tx_req.start === 1'b1) begin
			starts[1]++;
			sel[1] = tx_req.sel;
		end
		if (rx_rs === 1'b1)
			rsts[0]++;
		if (tx_rs === 1'b1)
			rsts[1]++;
	end

	task automatic complete_run();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk

	task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		read <= ~we;
		write <= we;
		address <= a;
		writedata <= wd;
		// Wait for the answer however long it takes; the watchdog ends a hang
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(n, e, x);
	endtask : rdc

	// Issue a command and poll until its bit clears itself
	task automatic cmd(input logic [31:0] c);
		logic [31:0] x;
		int k;
		wr(`REG_I2C_CMD, c);
		k = 0;
		do begin
			bus(1'b0, `REG_I2C_CMD, 32'h0, x);
			k++;
		end while (x !== 32'h0 && k < 400);
		chk("cmd_clear", 32'h0, x);
	endtask : cmd

	task automatic pulse_done(input bit d);
		@(posedge clk);
		if (d)
			tx_dma_done <= 1'b1;
		else
			rx_dma_done <= 1'b1;
		@(posedge clk);
		tx_dma_done <= 1'b0;
		rx_dma_done <= 1'b0;
	endtask : pulse_done

	task automatic err_pulse(input rx_err_t e);
		@(posedge clk);
		rx_err <= e;
		@(posedge clk);
		rx_err <= '0;
	endtask : err_pulse

	task automatic dma_dir(input bit d);
		int s;
		int n0;
		s = d ? 2 : 0;
		n0 = starts[d];
		wr(`REG_DMA_CTRL, 32'h1 << s);
		rdc("load_a", `REG_DMA_CTRL, 32'h1 << s);
		wr(`REG_DMA_CTRL, 32'h0);
		rdc("zero_write", `REG_DMA_CTRL, 32'h1 << s);
		wr(`REG_DMA_CTRL, 32'h2 << s);
		rdc("both_loaded", `REG_DMA_CTRL, 32'h3 << s);
		chk("first_start", n0 + 1, starts[d]);
		chk("first_sel", 32'h0, {31'h0, sel[d]});
		pulse_done(d);
		rdc("a_done", `REG_DMA_CTRL, 32'h2 << s);
		chk("second_start", n0 + 2, starts[d]);
		chk("second_sel", 32'h1, {31'h0, sel[d]});
		pulse_done(d);
		rdc("b_done", `REG_DMA_CTRL, 32'h0);
		// Both buffers loaded by one write while idle: A first, then B
		wr(`REG_DMA_CTRL, 32'h3 << s);
		rdc("pair_loaded", `REG_DMA_CTRL, 32'h3 << s);
		chk("pair_first_sel", 32'h0, {31'h0, sel[d]});
		pulse_done(d);
		rdc("pair_a_done", `REG_DMA_CTRL, 32'h2 << s);
		chk("pair_second_sel", 32'h1, {31'h0, sel[d]});
		chk("pair_starts", n0 + 4, starts[d]);
		pulse_done(d);
		rdc("pair_b_done", `REG_DMA_CTRL, 32'h0);
	endtask : dma_dir

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdc("ctrl_rst", `REG_DMA_CTRL, 32'h0);
		rdc("stat_rst", `REG_I2C_STATUS, 32'h0);
		rdc("ack_rst", `REG_I2C_ACK, 32'h0);
		chk("pins_low", 32'h0, {30'h0, scl_lo, sda_lo});
		wr(`REG_I2C_STATUS, 32'hf);
		rdc("stat_ro", `REG_I2C_STATUS, 32'h0);
		wr(16'h4400, 32'hffff);
		rdc("unmapped", 16'h4400, 32'h0);
		wr(`REG_INT_MASK, 32'h8);
		cmd(32'h4);
		rdc("start_fin", `REG_I2C_STATUS, 32'h8);
		@(negedge clk);
		chk("irq_set", 32'h1, {31'h0, irq});
		wr(`REG_INT_STATUS, 32'h3f);
		@(negedge clk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		// Slave stretches SCL on this byte
		stretch <= 1'b1;
		wr(`REG_I2C_DATA, 32'ha5);
		cmd(32'h2);
		rdc("sent", `REG_I2C_STATUS, 32'h2);
		chk("byte_out", 32'ha5, {24'h0, got});
		stretch <= 1'b0;
		nack <= 1'b1;
		wr(`REG_I2C_DATA, 32'h5a);
		cmd(32'h2);
		rdc("nacked", `REG_I2C_STATUS, 32'h3);
		nack <= 1'b0;
		rd_mode <= 1'b1;
		rd_byte <= 8'h3c;
		wr(`REG_I2C_ACK, 32'h1);
		rdc("ack_rw", `REG_I2C_ACK, 32'h1);
		cmd(32'h1);
		rdc("rcvd", `REG_I2C_STATUS, 32'h4);
		rdc("rx_byte", `REG_I2C_DATA, 32'h3c);
		chk("ack_out", 32'h0, {31'h0, ack_seen});
		wr(`REG_I2C_ACK, 32'h0);
		rd_byte <= 8'hc3;
		cmd(32'h1);
		rdc("rx_byte2", `REG_I2C_DATA, 32'hc3);
		chk("nack_out", 32'h1, {31'h0, ack_seen});
		rd_mode <= 1'b0;
		cmd(32'h8);
		rdc("stop_fin", `REG_I2C_STATUS, 32'h8);
		dma_dir(1'b0);
		dma_dir(1'b1);
		wr(`REG_DMA_CTRL, 32'h1);
		err_pulse(3'b100);
		rdc("frame_a", `REG_DMA_STATUS, 32'h101);
		b = rsts[0];
		wr(`REG_DMA_CTRL, 32'h10);
		rdc("rx_rst_ctrl", `REG_DMA_CTRL, 32'h0);
		chk("rx_rst_pulse", b + 1, rsts[0]);
		rdc("err_rst", `REG_DMA_STATUS, 32'h0);
		wr(`REG_DMA_CTRL, 32'h1);
		err_pulse(3'b011);
		rdc("par_ovf_a", `REG_DMA_STATUS, 32'h51);
		pulse_done(1'b0);
		rdc("err_stays", `REG_DMA_STATUS, 32'h50);
		wr(`REG_DMA_CTRL, 32'h1);
		rdc("err_reload", `REG_DMA_STATUS, 32'h1);
		pulse_done(1'b0);
		b = rsts[1];
		wr(`REG_DMA_CTRL, 32'h4);
		wr(`REG_DMA_CTRL, 32'h20);
		rdc("tx_rst_ctrl", `REG_DMA_CTRL, 32'h0);
		chk("tx_rst_pulse", b + 1, rsts[1]);
		complete_run();
	end
endmodule : serial_i2c_status_dma_control_tb
`default_nettype wire
